// ==== serial_irq_pkg.sv ====
/*
  Constants, types and state names for the serial interrupt slave.
  Assumes one link clock shared by every agent on the line and a
  system clock that is unrelated in phase.
*/
// Operation
// - Stop Frame is the line low two or three clocks; slaves measure it.
// - Two-clock stop: next cycle Quiet; slave may start from second clock.
// - Three-clock stop: next cycle Continuous; only the host may start.
// - Seventeen frames, no bridges: full update completes within 96 clocks.
// - Line is driven and sampled only on the rising link clock edge.
// - While reset-drive is asserted every agent floats the line.
// - Reset puts the slave in Continuous mode; no start until Quiet seen.
// - Quiet start: drive low one clock, then float, never drive high.
// - Frame is three clocks: low if level low, high if drove, then float.
// - Sample of frame N is 3N-1 clocks after the start pulse rising edge.
// - Quiet mode: a level change not yet carried triggers a start.
package serial_irq_pkg;

  // Frame and stop timing, in link clocks
  localparam int FRAME_COUNT_DEF = 17;
  localparam int LATENCY_MAX     = 96;
  localparam int STOP_QUIET_LEN  = 2;
  localparam int STOP_CONT_LEN   = 3;
  localparam int START_GAP       = 2;

  // Counter widths
  localparam int LOW_W = 3;
  localparam int GAP_W = 2;

  typedef logic [LOW_W-1:0] low_t;
  typedef logic [GAP_W-1:0] gap_t;

  // Frame phase codes
  typedef enum logic [1:0] {
    PH_SAMPLE,
    PH_RECOVER,
    PH_TURN
  } phase_e;

  // Link states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_KICK,
    ST_START,
    ST_FRAMES,
    ST_STOP
  } link_state_e;

  // Pin drive pair
  typedef struct packed {
    logic out;
    logic oe;
  } pin_s;

  localparam pin_s PIN_FLOAT = '{out: 1'b1, oe: 1'b0};

endpackage

// ==== serial_irq_stop_frame_slave.sv ====
/*
  Serial interrupt slave: frames the interrupt levels onto the shared
  line, follows the host's stop pulse and decides when it may start.
  Assumes the line is pulled up outside and that the link clock runs
  free; interrupt levels arrive on the system clock.
*/
`timescale 1ns/1ps

module serial_irq_stop_frame_slave
  import serial_irq_pkg::*;
#(
  parameter int NUM_FRAMES = FRAME_COUNT_DEF
) (
  // System side
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic [NUM_FRAMES-1:0] irqLevel,
  output logic                       quietModeSys,
  output logic                       linkBusySys,
  // Link side
  input  wire logic                  linkClk,
  input  wire logic                  serialInterruptPinIn,
  output logic                       serialInterruptPinOut,
  output logic                       serialInterruptPinOe
);

  localparam int FW = $clog2(NUM_FRAMES + 1);
  typedef logic [FW-1:0] frame_t;

  // Link reset sync
  logic linkRstMeta;
  logic linkRst;

  // Level crossing into link domain
  logic [NUM_FRAMES-1:0] lvlA;
  logic [NUM_FRAMES-1:0] lvlB;
  logic [NUM_FRAMES-1:0] lvlC;
  logic [NUM_FRAMES-1:0] levelLink;
  logic [NUM_FRAMES-1:0] next_levelLink;

  // Line sampling
  logic lineNow;
  logic linePrev;

  // Link state
  link_state_e           state;
  link_state_e           next_state;
  phase_e                phase;
  phase_e                next_phase;
  frame_t                frame;
  frame_t                next_frame;
  low_t                  lowCnt;
  low_t                  next_lowCnt;
  gap_t                  gapCnt;
  gap_t                  next_gapCnt;
  logic                  quietMode;
  logic                  next_quietMode;
  logic                  modeValid;
  logic                  next_modeValid;
  logic                  drove;
  logic                  next_drove;
  logic [NUM_FRAMES-1:0] sentLevel;
  logic [NUM_FRAMES-1:0] next_sentLevel;
  pin_s                  pin;
  pin_s                  next_pin;
  logic                  pending;
  logic                  rise;
  // Busy flag registered before it crosses domains
  logic                  busy;
  logic                  next_busy;

  // Status crossing into system domain
  logic [1:0] statA;
  logic [1:0] statB;
  logic [1:0] statC;
  logic [1:0] statSys;
  logic [1:0] next_statSys;

  // Reset release on link clock; asserts at once
  // Release is retimed so no link flop leaves reset on a skewed edge
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      linkRstMeta <= 1'b1;
      linkRst     <= 1'b1;
    end else begin
      linkRstMeta <= 1'b0;
      linkRst     <= linkRstMeta;
    end
  end

  // Levels are asynchronous here; one flop alone could go metastable
  // Three-stage chain per interrupt level
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FRAMES; gi++) begin : g_lvl
      always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
          lvlA[gi] <= 1'b1;
          lvlB[gi] <= 1'b1;
          lvlC[gi] <= 1'b1;
        end else begin
          lvlA[gi] <= irqLevel[gi];
          lvlB[gi] <= lvlA[gi];
          lvlC[gi] <= lvlB[gi];
        end
      end
      // Accept change once second and third agree
      always_comb begin
        next_levelLink[gi] = levelLink[gi];
        if (lvlB[gi] == lvlC[gi]) begin
          next_levelLink[gi] = lvlC[gi];
        end
      end
    end
  endgenerate

  // Line is synchronous to the link clock; one register suffices
  // Accepted levels and line sample
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      levelLink <= '1;
      lineNow   <= 1'b1;
      linePrev  <= 1'b1;
    end else begin
      levelLink <= next_levelLink;
      lineNow   <= serialInterruptPinIn;
      linePrev  <= lineNow;
    end
  end

  // Rise marks the end of the start pulse; stop end is lineNow high with lowCnt nonzero
  assign rise    = lineNow & ~linePrev;
  // Pending: an accepted level not yet carried in its frame
  assign pending = |(levelLink ^ sentLevel);

  // Link sequencer next values
  always_comb begin
    next_state     = state;
    next_phase     = phase;
    next_frame     = frame;
    next_lowCnt    = lowCnt;
    next_gapCnt    = gapCnt;
    next_quietMode = quietMode;
    next_modeValid = modeValid;
    next_drove     = 1'b0;
    next_sentLevel = sentLevel;
    next_pin       = PIN_FLOAT;
    case (state)
      ST_IDLE: begin
        // Clocks since the stop pulse rose; saturates
        if (gapCnt != '1) begin
          next_gapCnt = gapCnt + gap_t'(1);
        end
        if (!lineNow) begin
          // Host or another slave began a start pulse
          next_state = ST_START;
        end else if (quietMode && modeValid && pending &&
                     gapCnt >= gap_t'(START_GAP - 1)) begin
          next_state   = ST_KICK;
          next_pin.out = 1'b0;
          next_pin.oe  = 1'b1;
        end
      end
      ST_KICK: begin
        // One clock low done; float, host keeps it low
        next_state = ST_START;
      end
      ST_START: begin
        // Wait for the start pulse to end
        if (rise) begin
          // First sample slot opens at this edge, clock 2 after the rise
          next_state = ST_FRAMES;
          next_phase = PH_SAMPLE;
          next_frame = frame_t'(1);
        end
      end
      ST_FRAMES: begin
        case (phase)
          PH_SAMPLE:  next_phase = PH_RECOVER;
          PH_RECOVER: next_phase = PH_TURN;
          PH_TURN: begin
            next_phase = PH_SAMPLE;
            next_frame = frame + frame_t'(1);
          end
          default:    next_phase = PH_TURN;
        endcase
        if (phase == PH_TURN && frame == frame_t'(NUM_FRAMES)) begin
          // Last frame ended; wait for host stop pulse
          next_state  = ST_STOP;
          next_lowCnt = '0;
        end
      end
      ST_STOP: begin
        // Count low clocks of the host's stop pulse
        if (!lineNow) begin
          if (lowCnt != '1) begin
            next_lowCnt = lowCnt + low_t'(1);
          end
        end else if (lowCnt != '0) begin
          // Rising edge of stop pulse: decode width
          next_state  = ST_IDLE;
          next_gapCnt = '0;
          if (lowCnt == low_t'(STOP_QUIET_LEN)) begin
            next_quietMode = 1'b1;
            next_modeValid = 1'b1;
          end else if (lowCnt == low_t'(STOP_CONT_LEN)) begin
            next_quietMode = 1'b0;
            next_modeValid = 1'b1;
          end else begin
            next_modeValid = 1'b0;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Drive for the frame slot that opens at this edge
    if (next_state == ST_FRAMES && next_phase == PH_SAMPLE) begin
      next_sentLevel[next_frame - frame_t'(1)] =
        levelLink[next_frame - frame_t'(1)];
      if (!levelLink[next_frame - frame_t'(1)]) begin
        next_pin.out = 1'b0;
        next_pin.oe  = 1'b1;
        next_drove   = 1'b1;
      end
    end else if (next_state == ST_FRAMES && next_phase == PH_RECOVER && drove) begin
      next_pin.out = 1'b1;
      next_pin.oe  = 1'b1;
    end
    // Turn-around keeps the default float
    next_busy = (next_state != ST_IDLE);
  end

  // Link sequencer registers; reset floats the line
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      state     <= ST_IDLE;
      phase     <= PH_TURN;
      frame     <= '0;
      lowCnt    <= '0;
      gapCnt    <= '0;
      quietMode <= 1'b0;
      modeValid <= 1'b0;
      drove     <= 1'b0;
      sentLevel <= '1;
      pin       <= PIN_FLOAT;
      busy      <= 1'b0;
    end else begin
      state     <= next_state;
      phase     <= next_phase;
      frame     <= next_frame;
      lowCnt    <= next_lowCnt;
      gapCnt    <= next_gapCnt;
      quietMode <= next_quietMode;
      modeValid <= next_modeValid;
      drove     <= next_drove;
      sentLevel <= next_sentLevel;
      pin       <= next_pin;
      busy      <= next_busy;
    end
  end

  // Pin drive straight from its register
  assign serialInterruptPinOut = pin.out;
  assign serialInterruptPinOe  = pin.oe;

  // Only registered single bits cross; nothing decoded ahead of stage one
  // Status chain into system domain
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      statA   <= '0;
      statB   <= '0;
      statC   <= '0;
      statSys <= '0;
    end else begin
      statA   <= {busy, quietMode};
      statB   <= statA;
      statC   <= statB;
      statSys <= next_statSys;
    end
  end

  // Accept status bit once second and third agree
  genvar si;
  generate
    for (si = 0; si < $bits(statSys); si++) begin : g_stat
      always_comb begin
        next_statSys[si] = statSys[si];
        if (statB[si] == statC[si]) begin
          next_statSys[si] = statC[si];
        end
      end
    end
  endgenerate

  assign quietModeSys = statSys[0];
  assign linkBusySys  = statSys[1];

endmodule

// ==== serial_irq_stop_frame_slave_properties.sv ====
/* Checker for the serial interrupt slave, bound to its ports.
   Assumes the pin input sees the resolved, pulled-up line. */
`timescale 1ns/1ps
module serial_irq_stop_frame_slave_properties
  import serial_irq_pkg::*;
#(parameter int NUM_FRAMES = FRAME_COUNT_DEF) (
  // System side
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic [NUM_FRAMES-1:0] irqLevel,
  input wire logic                  quietModeSys,
  input wire logic                  linkBusySys,
  // Link side
  input wire logic                  linkClk,
  input wire logic                  serialInterruptPinIn,
  input wire logic                  serialInterruptPinOut,
  input wire logic                  serialInterruptPinOe
);
  logic [2:0] lowRun;
  logic [2:0] lastStop;
  logic [6:0] pos;
  wire        oe = serialInterruptPinOe;
  wire        lo = oe && !serialInterruptPinOut;
  wire        hi = oe && serialInterruptPinOut;
  wire        inFrame = pos < 7'(3 * NUM_FRAMES);
  default clocking cb @(posedge linkClk); endclocking

  // Low run, last pulse width, clocks since start pulse rose
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      lowRun <= 3'h0;
      lastStop <= 3'h3;
      pos <= 7'h7f;
    end else begin
      lowRun <= serialInterruptPinIn ? 3'h0 : lowRun + 3'(lowRun != 3'h7);
      if (serialInterruptPinIn && lowRun > 3'h1) lastStop <= lowRun;
      pos <= (serialInterruptPinIn && lowRun > 3'h3) ? 7'h00 : pos + 7'(pos != 7'h7f);
    end
  end

  chk_reset_float: assert property (rst |-> !oe)
    else $error("line driven in reset");
  chk_high_after_low: assert property (disable iff (rst) hi |-> $past(lo))
    else $error("high drive without low");
  chk_release_high: assert property (disable iff (rst) hi |=> !oe)
    else $error("no turn-around release");
  chk_frame_recover: assert property (disable iff (rst) lo && inFrame |=> hi)
    else $error("no recovery drive");
  chk_start_release: assert property (disable iff (rst) lo && !inFrame |=> !oe)
    else $error("start pulse not released");
  chk_frame_slot: assert property (disable iff (rst) lo && inFrame |-> pos % 3 == 1)
    else $error("drive outside sample slot");
  chk_frame_level: assert property (disable iff (rst)
    inFrame && pos % 3 == 1 |-> oe == !irqLevel[pos / 3]) else $error("wrong frame level");
  chk_quiet_start: assert property (disable iff (rst) lo && !inFrame |-> lastStop == 3'h2)
    else $error("start outside quiet mode");
endmodule

// ==== serial_irq_host_model.sv ====
/* Host model: starts cycles on request, extends slave start pulses,
   samples each frame and ends each cycle with a stop pulse. */
`timescale 1ns/1ps
module serial_irq_host_model
  import serial_irq_pkg::*;
#(parameter int NUM_FRAMES = FRAME_COUNT_DEF) (
  // Link
  input  wire logic             linkClk,
  input  wire logic             rst,
  input  wire logic             line,
  output logic                  hostOut,
  output logic                  hostOe,
  // Bench side
  input  var int                goCount,
  input  wire logic [2:0]       stopLen,
  output logic [NUM_FRAMES-1:0] frameBits,
  output int                    cycles,
  output int                    slaveStarts
);
  int served = 0;
  bit own;

  // One cycle per bench request or slave start pulse
  always begin
    {hostOut, hostOe} = 2'h2;
    frameBits = '1;
    cycles = 0;
    slaveStarts = 0;
    forever begin
      @(posedge linkClk);
      if (!rst && (goCount != served || !line)) begin
        own = line;
        if (own) served++;
        else slaveStarts++;
        hostOe <= 1'b1;
        hostOut <= 1'b0;
        repeat (own ? 4 : 3) @(posedge linkClk);
        hostOut <= 1'b1;
        @(posedge linkClk) hostOe <= 1'b0;
        for (int k = 1; k <= 3 * NUM_FRAMES; k++) begin
          @(posedge linkClk);
          if (k % 3 == 2) frameBits[k / 3] = line;
        end
        @(posedge linkClk);
        hostOut <= 1'b0;
        hostOe <= 1'b1;
        repeat (stopLen) @(posedge linkClk);
        hostOut <= 1'b1;
        @(posedge linkClk) hostOe <= 1'b0;
        cycles++;
        @(posedge linkClk);
      end
    end
  end
endmodule

// ==== serial_irq_stop_frame_slave_bench.sv ====
/* Bench for the serial interrupt slave with random levels and stop widths.
   Assumes the host model and the checker are compiled first. */
`timescale 1ns/1ps
module serial_irq_stop_frame_slave_bench;
  import serial_irq_pkg::*;
  localparam int NF = FRAME_COUNT_DEF;
  logic          clk_sys = 1'b0;
  logic          linkClk = 1'b0;
  logic          rst = 1'b1;
  logic [NF-1:0] irqLevel = '1;
  logic [NF-1:0] nextLevel;
  logic [NF-1:0] frameBits;
  logic [2:0]    stopLen = 3'h3;
  logic          quietModeSys, linkBusySys, pinOut, pinOe, hostOut, hostOe;
  logic          expQuiet, blocked, expStart;
  int            goCount, cycles, slaveStarts, fail_count, total_checks, ticks, seed, n, k;
  wire           line = pinOe ? pinOut : (hostOe ? hostOut : 1'b1);

  // System and link clocks, unrelated in phase
  always #50 clk_sys = ~clk_sys;
  initial #17 forever #62.5 linkClk = ~linkClk;

  serial_irq_stop_frame_slave serial_irq_stop_frame_slave_i (
    .clk_sys(clk_sys), .rst(rst), .irqLevel(irqLevel), .quietModeSys(quietModeSys),
    .linkBusySys(linkBusySys), .linkClk(linkClk), .serialInterruptPinIn(line),
    .serialInterruptPinOut(pinOut), .serialInterruptPinOe(pinOe));

  serial_irq_host_model serial_irq_host_model_i (
    .linkClk(linkClk), .rst(rst), .line(line), .hostOut(hostOut), .hostOe(hostOe),
    .goCount(goCount), .stopLen(stopLen), .frameBits(frameBits), .cycles(cycles),
    .slaveStarts(slaveStarts));

  task automatic check(input logic [NF-1:0] got, input logic [NF-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    ticks++;
    if (ticks == 3000) begin
      fail_count++;
      end_of_test();
    end
  end

  // Cycles with level changes, valid and invalid stop widths
  initial begin
    seed = 32'h1e16_9424;
    expQuiet = 1'b0;
    blocked = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 12; i++) begin
      n = slaveStarts;
      k = cycles;
      nextLevel = (i == 5) ? irqLevel : NF'($random(seed));
      expStart = expQuiet && !blocked && (nextLevel !== irqLevel);
      irqLevel <= nextLevel;
      // Last cycle leaves the line idle in Continuous mode
      stopLen <= (i == 2 || i == 4) ? 3'h2 : (i == 3) ? 3'h1 :
                 (i == 11) ? 3'h3 : 3'(2 + ($random(seed) & 1));
      repeat (40) @(posedge clk_sys);
      check(NF'(slaveStarts != n), NF'(expStart));
      if (!expStart) goCount++;
      repeat (20) @(posedge clk_sys);
      check(NF'(linkBusySys), NF'(1));
      repeat (150) if (cycles == k) @(posedge clk_sys);
      check(NF'(cycles - k), NF'(1));
      // Read results only after the cycle has settled
      repeat (8) @(posedge clk_sys);
      check(frameBits, nextLevel);
      check(NF'(linkBusySys), NF'(0));
      if (stopLen != 3'h1) expQuiet = (stopLen == 3'h2);
      blocked = (stopLen == 3'h1);
      check(NF'(quietModeSys), NF'(expQuiet));
    end
    end_of_test();
  end
endmodule

bind serial_irq_stop_frame_slave serial_irq_stop_frame_slave_properties #(
  .NUM_FRAMES(NUM_FRAMES)) chk_i (
  .clk_sys(clk_sys), .rst(rst), .irqLevel(irqLevel), .quietModeSys(quietModeSys),
  .linkBusySys(linkBusySys), .linkClk(linkClk), .serialInterruptPinIn(serialInterruptPinIn),
  .serialInterruptPinOut(serialInterruptPinOut), .serialInterruptPinOe(serialInterruptPinOe));
